// ==== rad_consts.vh ====
// address map constants for the register address decoder
`ifndef RAD_CONSTS_VH
`define RAD_CONSTS_VH
`define RAD_SPACE_SIZE    11'h400
`define RAD_UP_BASE       16'ha000
`define RAD_PAGE_W        2
`define RAD_GLOBAL_END    8'h10
`define RAD_ARB_BASE      10'h010
`define RAD_ARB_SIZE      10'h010
`define RAD_PWR_BASE      10'h020
`define RAD_PWR_SIZE      10'h020
`define RAD_RTC_BASE      10'h040
`define RAD_RTC_SIZE      10'h020
`define RAD_LDO_BASE      10'h060
`define RAD_LDO_SIZE      10'h020
`define RAD_SWREG_BASE    10'h080
`define RAD_SWREG_SIZE    10'h010
`define RAD_CHRG_BASE     10'h090
`define RAD_CHRG_SIZE     10'h010
`define RAD_TIMER_BASE    10'h0a0
`define RAD_TIMER_SIZE    10'h010
`define RAD_TOUCH_BASE    10'h0c0
`define RAD_TOUCH_SIZE    10'h040
`define RAD_AUDIO_BASE    10'h100
`define RAD_AUDIO_SIZE    10'h0f0
`define RAD_SPK_BASE      10'h200
`define RAD_SPK_SIZE      10'h0f0
`define RAD_GLOBAL_BASE   10'h000
`define RAD_GLOBAL_SIZE   10'h010
`define RAD_NMOD          11
`define RAD_SEL_W         4
`define RAD_SEL_NONE      4'hf
`endif

// ==== rad_decoder.v ====
// register address decoder with two-master arbitration and access-type logic
`timescale 1ns/1ns
`include "rad_consts.vh"
module rad_decoder (
  input  wire        mclk,
  input  wire        rst_n,
  // serial slave side
  input  wire        ser_req,
  input  wire        ser_wr,
  input  wire [1:0]  ser_page,
  input  wire [7:0]  ser_offs,
  input  wire [7:0]  ser_wdata,
  output reg         ser_done_q,
  output reg  [7:0]  ser_rdata_q,
  // embedded processor side
  input  wire        up_req,
  input  wire        up_wr,
  input  wire [15:0] up_addr,
  input  wire [7:0]  up_wdata,
  output reg         up_done_q,
  output reg  [7:0]  up_rdata_q,
  // module side
  output reg  [10:0] mod_sel_q,
  output reg  [9:0]  mod_offs_q,
  output reg         mod_wr_q,
  output reg         mod_rd_q,
  output reg  [7:0]  mod_wdata_q,
  input  wire [7:0]  mod_rdata,
  input  wire [7:0]  mod_ro_mask,
  input  wire [7:0]  mod_w1c_mask,
  input  wire [7:0]  mod_w1a_mask,
  output reg  [7:0]  mod_wmask_q,
  output reg  [7:0]  mod_clr_q,
  output reg  [7:0]  mod_act_q
);

  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_DONE = 2'h2;

  reg  [1:0]  st_q;
  reg  [1:0]  st_d;
  reg         own_up_q;
  reg         last_up_q;
  reg  [9:0]  addr_q;
  reg         wr_q;
  reg  [7:0]  wdata_q;
  reg  [3:0]  sel_q;
  reg  [7:0]  rdata_q;

  // flat module index of a 10-bit space address, none if reserved
  function [3:0] dec_sel;
    input [9:0] a;
    begin
      if (a[7:0] < `RAD_GLOBAL_END)
        dec_sel = 4'h0;
      else if (a >= `RAD_ARB_BASE && a < `RAD_ARB_BASE + `RAD_ARB_SIZE)
        dec_sel = 4'h1;
      else if (a >= `RAD_PWR_BASE && a < `RAD_PWR_BASE + `RAD_PWR_SIZE)
        dec_sel = 4'h2;
      else if (a >= `RAD_RTC_BASE && a < `RAD_RTC_BASE + `RAD_RTC_SIZE)
        dec_sel = 4'h3;
      else if (a >= `RAD_LDO_BASE && a < `RAD_LDO_BASE + `RAD_LDO_SIZE)
        dec_sel = 4'h4;
      else if (a >= `RAD_SWREG_BASE && a < `RAD_SWREG_BASE + `RAD_SWREG_SIZE)
        dec_sel = 4'h5;
      else if (a >= `RAD_CHRG_BASE && a < `RAD_CHRG_BASE + `RAD_CHRG_SIZE)
        dec_sel = 4'h6;
      else if (a >= `RAD_TIMER_BASE && a < `RAD_TIMER_BASE + `RAD_TIMER_SIZE)
        dec_sel = 4'h7;
      else if (a >= `RAD_TOUCH_BASE && a < `RAD_TOUCH_BASE + `RAD_TOUCH_SIZE)
        dec_sel = 4'h8;
      else if (a >= `RAD_AUDIO_BASE && a < `RAD_AUDIO_BASE + `RAD_AUDIO_SIZE)
        dec_sel = 4'h9;
      else if (a >= `RAD_SPK_BASE && a < `RAD_SPK_BASE + `RAD_SPK_SIZE)
        dec_sel = 4'ha;
      else
        dec_sel = `RAD_SEL_NONE;
    end
  endfunction

  // base of the module owning an index
  function [9:0] dec_base;
    input [3:0] s;
    begin
      case (s)
        4'h1:    dec_base = `RAD_ARB_BASE;
        4'h2:    dec_base = `RAD_PWR_BASE;
        4'h3:    dec_base = `RAD_RTC_BASE;
        4'h4:    dec_base = `RAD_LDO_BASE;
        4'h5:    dec_base = `RAD_SWREG_BASE;
        4'h6:    dec_base = `RAD_CHRG_BASE;
        4'h7:    dec_base = `RAD_TIMER_BASE;
        4'h8:    dec_base = `RAD_TOUCH_BASE;
        4'h9:    dec_base = `RAD_AUDIO_BASE;
        4'ha:    dec_base = `RAD_SPK_BASE;
        default: dec_base = `RAD_GLOBAL_BASE;
      endcase
    end
  endfunction

  // byte size of the module owning an index
  function [9:0] dec_size;
    input [3:0] s;
    begin
      case (s)
        4'h1:    dec_size = `RAD_ARB_SIZE;
        4'h2:    dec_size = `RAD_PWR_SIZE;
        4'h3:    dec_size = `RAD_RTC_SIZE;
        4'h4:    dec_size = `RAD_LDO_SIZE;
        4'h5:    dec_size = `RAD_SWREG_SIZE;
        4'h6:    dec_size = `RAD_CHRG_SIZE;
        4'h7:    dec_size = `RAD_TIMER_SIZE;
        4'h8:    dec_size = `RAD_TOUCH_SIZE;
        4'h9:    dec_size = `RAD_AUDIO_SIZE;
        4'ha:    dec_size = `RAD_SPK_SIZE;
        default: dec_size = `RAD_GLOBAL_SIZE;
      endcase
    end
  endfunction

  // serial view: page selects high bits, global offsets ignore page
  wire [9:0] ser_flat = (ser_offs < `RAD_GLOBAL_END) ? {2'h0, ser_offs}
                                                     : {ser_page, ser_offs};
  // processor window check
  wire [15:0] up_rel  = up_addr - `RAD_UP_BASE;
  wire        up_in   = (up_addr >= `RAD_UP_BASE) &&
                        (up_rel < {5'h00, `RAD_SPACE_SIZE});
  wire [9:0]  up_flat = up_in ? up_rel[9:0] : 10'h3ff;
  wire [9:0]  up_glob = (up_flat[7:0] < `RAD_GLOBAL_END) ? {2'h0, up_flat[7:0]} : up_flat;

  // fair alternation when both request together
  wire grant_up = up_req && (!ser_req || !last_up_q);

  wire [9:0] pick_addr = grant_up ? (up_in ? up_glob : 10'h3ff) : ser_flat;
  wire [3:0] pick_sel  = (grant_up && !up_in) ? `RAD_SEL_NONE : dec_sel(pick_addr);

  // one range compare per module; global bank wins in every page
  wire                 pick_glob = (pick_addr[7:0] < `RAD_GLOBAL_END);
  wire [`RAD_NMOD-1:0] pick_hot;
  assign pick_hot[0] = pick_glob;
  genvar gi;
  generate
    for (gi = 1; gi < `RAD_NMOD; gi = gi + 1) begin : g_hit
      localparam [3:0] IDX = gi;
      assign pick_hot[gi] = !pick_glob &&
                            (pick_addr >= dec_base(IDX)) &&
                            (pick_addr < dec_base(IDX) + dec_size(IDX));
    end
  endgenerate

  // an access is taken only from idle
  wire take = (st_q == ST_IDLE) && (up_req || ser_req);

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (up_req || ser_req)
          st_d = ST_READ;
      end
      ST_READ: st_d = ST_DONE;
      ST_DONE: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  // access capture: owner, address, write data, module index
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= ST_IDLE;
      own_up_q  <= 1'b0;
      last_up_q <= 1'b0;
      addr_q    <= 10'h000;
      wr_q      <= 1'b0;
      wdata_q   <= 8'h00;
      sel_q     <= `RAD_SEL_NONE;
    end else begin
      st_q <= st_d;
      if (take) begin
        // one master per access
        own_up_q  <= grant_up;
        last_up_q <= grant_up;
        addr_q    <= pick_addr;
        wr_q      <= grant_up ? up_wr : ser_wr;
        wdata_q   <= grant_up ? up_wdata : ser_wdata;
        sel_q     <= pick_sel;
      end
    end
  end

  // module select and offset hold until the next access
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mod_sel_q  <= {`RAD_NMOD{1'b0}};
      mod_offs_q <= 10'h000;
      mod_rd_q   <= 1'b0;
    end else begin
      mod_rd_q <= 1'b0;
      if (take) begin
        mod_sel_q  <= pick_hot;
        mod_offs_q <= pick_addr - dec_base(pick_sel);
        // read first, so a write can merge per-bit types
        mod_rd_q   <= (pick_sel != `RAD_SEL_NONE);
      end
    end
  end

  // write phase: store mask, clear and action pulses
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mod_wr_q    <= 1'b0;
      mod_wdata_q <= 8'h00;
      mod_wmask_q <= 8'h00;
      mod_clr_q   <= 8'h00;
      mod_act_q   <= 8'h00;
    end else begin
      mod_wr_q  <= 1'b0;
      mod_clr_q <= 8'h00;
      mod_act_q <= 8'h00;
      if (st_q == ST_READ && wr_q && sel_q != `RAD_SEL_NONE) begin
        mod_wr_q    <= 1'b1;
        // plain bits take data; read-only and typed bits keep value
        mod_wmask_q <= ~(mod_ro_mask | mod_w1c_mask | mod_w1a_mask);
        mod_wdata_q <= wdata_q;
        mod_clr_q   <= wdata_q & mod_w1c_mask & ~mod_ro_mask;
        mod_act_q   <= wdata_q & mod_w1a_mask & ~mod_ro_mask;
      end
    end
  end

  // read data, zero for reserved ranges
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (st_q == ST_READ) begin
      rdata_q <= (sel_q == `RAD_SEL_NONE) ? 8'h00 : mod_rdata;
    end
  end

  // processor answer
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      up_done_q  <= 1'b0;
      up_rdata_q <= 8'h00;
    end else begin
      up_done_q <= 1'b0;
      if (st_q == ST_DONE && own_up_q) begin
        up_done_q  <= 1'b1;
        up_rdata_q <= rdata_q;
      end
    end
  end

  // serial answer
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ser_done_q  <= 1'b0;
      ser_rdata_q <= 8'h00;
    end else begin
      ser_done_q <= 1'b0;
      if (st_q == ST_DONE && !own_up_q) begin
        ser_done_q  <= 1'b1;
        ser_rdata_q <= rdata_q;
      end
    end
  end

endmodule

// ==== rad_mod_model.sv ====
// module-side model: read data and bit types at the selected offset
`timescale 1ns/1ns
module rad_mod_model (
  input  wire [9:0] mod_offs_q,
  output wire [7:0] mod_rdata,
  output wire [7:0] mod_ro_mask,
  output wire [7:0] mod_w1c_mask,
  output wire [7:0] mod_w1a_mask
);
  // drives a pattern even when nothing is selected
  // no reserved bits here, so plain writes stay legal
  assign mod_rdata    = mod_offs_q[7:0] ^ 8'h5a;
  assign mod_ro_mask  = 8'h81 << mod_offs_q[0];
  assign mod_w1c_mask = 8'h24 << mod_offs_q[0];
  assign mod_w1a_mask = 8'h18 >> mod_offs_q[0];
endmodule

// ==== rad_decoder_properties.sv ====
// concurrent checks on the register address decoder ports
`timescale 1ns/1ns
module rad_decoder_props (
  input wire        mclk,
  input wire        rst_n,
  input wire        ser_done_q,
  input wire        up_done_q,
  input wire [10:0] mod_sel_q,
  input wire        mod_wr_q,
  input wire        mod_rd_q,
  input wire [7:0]  mod_wdata_q,
  input wire [7:0]  mod_ro_mask,
  input wire [7:0]  mod_w1c_mask,
  input wire [7:0]  mod_w1a_mask,
  input wire [7:0]  mod_wmask_q,
  input wire [7:0]  mod_clr_q,
  input wire [7:0]  mod_act_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_strobe; mod_rd_q; endsequence
  sequence s_answer; ##2 (ser_done_q ^ up_done_q); endsequence
  a_rd_then_done: assert property (s_strobe |-> s_answer)
    else $error("done missing after read strobe");
  a_done_alone: assert property (!(ser_done_q && up_done_q))
    else $error("both masters done together");
  a_done_pulse: assert property ((ser_done_q || up_done_q) |=> !(ser_done_q || up_done_q))
    else $error("done longer than one cycle");
  a_wr_after_rd: assert property (mod_wr_q |-> $past(mod_rd_q))
    else $error("write strobe without read strobe");
  a_clr_bits: assert property (mod_wr_q |-> mod_clr_q == (mod_wdata_q & mod_w1c_mask))
    else $error("clear bits wrong");
  a_act_bits: assert property (mod_wr_q |-> mod_act_q == (mod_wdata_q & mod_w1a_mask))
    else $error("action bits wrong");
  a_ro_kept: assert property (mod_wr_q |->
    (mod_wmask_q & (mod_ro_mask | mod_w1c_mask | mod_w1a_mask)) == 8'h00)
    else $error("store mask covers typed bits");
  a_quiet_pulse: assert property (!mod_wr_q |-> (mod_clr_q | mod_act_q) == 8'h00)
    else $error("clear or action outside write");
  a_rsv_silent: assert property (mod_sel_q == 11'h000 |-> !(mod_rd_q || mod_wr_q))
    else $error("strobe with no module selected");
  a_sel_onehot: assert property ($onehot0(mod_sel_q))
    else $error("module select not one-hot");
endmodule
bind rad_decoder rad_decoder_props u_props (.mclk, .rst_n, .ser_done_q, .up_done_q,
  .mod_sel_q, .mod_wr_q, .mod_rd_q, .mod_wdata_q, .mod_ro_mask, .mod_w1c_mask,
  .mod_w1a_mask, .mod_wmask_q, .mod_clr_q, .mod_act_q);

// ==== test_register_address_decoder.sv ====
// self-checking bench for the register address decoder
`timescale 1ns/1ns
module test_register_address_decoder;
  typedef struct {logic [10:0] s; logic [9:0] o; logic [7:0] r; logic w; logic m;} rad_exp_t;
  reg         mclk = 0, rst_n = 0, ser_req = 0, ser_wr = 0, up_req = 0, up_wr = 0;
  reg  [1:0]  ser_page = 0;
  reg  [7:0]  ser_offs = 0, ser_wdata = 0, up_wdata = 0;
  reg  [15:0] up_addr = 0;
  wire        ser_done_q, up_done_q, mod_wr_q, mod_rd_q;
  wire [7:0]  ser_rdata_q, up_rdata_q, mod_wdata_q, mod_rdata, ro, w1c, w1a, wm, clr, act;
  wire [10:0] mod_sel_q;
  wire [9:0]  mod_offs_q;
  int         fails = 0, compares = 0, i, k;
  logic [9:0] bs [1:10] = '{10'h010, 10'h020, 10'h040, 10'h060, 10'h080, 10'h090, 10'h0a0,
                            10'h0c0, 10'h100, 10'h200};
  logic [9:0] sz [1:10] = '{10'h010, 10'h020, 10'h020, 10'h020, 10'h010, 10'h010, 10'h010,
                            10'h040, 10'h0f0, 10'h0f0};
  logic [9:0] rs [0:5] = '{10'h0b0, 10'h0bf, 10'h1f0, 10'h2ff, 10'h300, 10'h3ff};
  rad_exp_t   q [$];
  rad_exp_t   me;
  rad_decoder u_dut (.mclk(mclk), .rst_n(rst_n), .ser_req(ser_req), .ser_wr(ser_wr),
    .ser_page(ser_page), .ser_offs(ser_offs), .ser_wdata(ser_wdata), .ser_done_q(ser_done_q),
    .ser_rdata_q(ser_rdata_q), .up_req(up_req), .up_wr(up_wr), .up_addr(up_addr),
    .up_wdata(up_wdata), .up_done_q(up_done_q), .up_rdata_q(up_rdata_q),
    .mod_sel_q(mod_sel_q), .mod_offs_q(mod_offs_q), .mod_wr_q(mod_wr_q), .mod_rd_q(mod_rd_q),
    .mod_wdata_q(mod_wdata_q), .mod_rdata(mod_rdata), .mod_ro_mask(ro), .mod_w1c_mask(w1c),
    .mod_w1a_mask(w1a), .mod_wmask_q(wm), .mod_clr_q(clr), .mod_act_q(act));
  rad_mod_model u_model (.mod_offs_q(mod_offs_q), .mod_rdata(mod_rdata), .mod_ro_mask(ro),
    .mod_w1c_mask(w1c), .mod_w1a_mask(w1a));
  initial forever #5 mclk = ~mclk;
  task chk(input logic [10:0] seen, input logic [10:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task note(input logic [9:0] a, input logic w, input logic m, input logic [7:0] d);
    rad_exp_t e;
    e = '{11'h000, 10'h000, w ? d : 8'h00, w, m};
    if (a[7:0] < 8'h10) e = '{11'h001, {6'h00, a[3:0]}, e.r, w, m};
    else for (int j = 1; j <= 10; j++) if (a >= bs[j] && a < bs[j] + sz[j]) begin
      e.s = 11'h001 << j;
      e.o = a - bs[j];
    end
    if (e.s == 11'h000) e.r = 8'h00;
    else if (!w) e.r = e.o[7:0] ^ 8'h5a;
    q.push_back(e);
  endtask
  task automatic acc(input logic m, input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk) #1;
    if (m) {up_req, up_wr, up_addr, up_wdata} = {1'b1, w, 16'ha000 + {6'h00, a}, d};
    else {ser_req, ser_wr, ser_page, ser_offs, ser_wdata} = {1'b1, w, a, d};
    for (n = 0; n < 20 && (m ? up_done_q : ser_done_q) !== 1'b1; n++) @(posedge mclk) #1;
    if (n == 20) fails++;
    if (m) up_req = 0;
    else ser_req = 0;
  endtask
  task run(input logic m, input logic w, input logic [9:0] a, input logic [7:0] d);
    note(a, w, m, d);
    acc(m, w, a, d);
  endtask
  always @(posedge mclk) begin
    #1;
    if (ser_done_q === 1'b1 || up_done_q === 1'b1) begin
      if (q.size() == 0) fails++;
      else begin
        me = q.pop_front();
        chk(up_done_q, me.m);
        chk(mod_sel_q, me.s);
        if (me.s != 11'h000) chk(mod_offs_q, me.o);
        chk(me.w && me.s != 0 ? mod_wdata_q : me.m ? up_rdata_q : ser_rdata_q, me.r);
      end
    end
  end
  initial begin
    void'($urandom(42));
    repeat (10) @(posedge mclk);
    #1 rst_n = 1;
    note(10'h105, 0, 1, 0);
    note(10'h025, 0, 0, 0);
    fork
      acc(0, 0, 10'h025, 8'h00);
      acc(1, 0, 10'h105, 8'h00);
    join
    for (i = 1; i <= 10; i++) for (k = 0; k < 4; k++)
      run(k[0], k[1], k[1] ? bs[i] + sz[i] - 10'h001 : bs[i], 8'($urandom));
    for (i = 0; i < 12; i++) run(i[0], i[1], rs[i % 6], 8'($urandom));
    repeat (40) run(1'($urandom), 1'($urandom), 10'($urandom), 8'($urandom));
    test_done;
  end
  initial begin
    #100000;
    fails++;
    test_done;
  end
endmodule
